// file: pkg/acp_map.vh
// Register offsets, reset values, field positions and status constants
`ifndef ACP_MAP_VH
`define ACP_MAP_VH
`define ACP_ADDR_PWR 7'h00
`define ACP_ADDR_FMT 7'h01
`define ACP_ADDR_DRV 7'h02
`define ACP_ADDR_TIM 7'h03
`define ACP_ADDR_TRA 7'h04
`define ACP_ADDR_TRB 7'h05
`define ACP_ADDR_DIV 7'h06
`define ACP_ADDR_RSV 7'h07
`define ACP_ADDR_CMI 7'h08
`define ACP_ADDR_KEY 7'h0A
`define ACP_RST_PWR 8'h03
`define ACP_RST_FMT 8'h00
`define ACP_RST_DRV 8'h00
`define ACP_RST_TIM 8'h6D
`define ACP_RST_TRA 8'h00
`define ACP_RST_TRB 8'h00
`define ACP_RST_DIV 8'h00
`define ACP_RST_CMI 8'h00
`define ACP_KEY_VALUE 8'h5A
`define ACP_FMT_MUX 1
`define ACP_FMT_MUXCH 2
`define ACP_FMT_ORDA 3
`define ACP_FMT_ORDB 4
`define ACP_PWR_CHA 0
`define ACP_PWR_CHB 1
`define ACP_PWR_STBY 2
`define ACP_PWR_AVG 3
`define ACP_ST_BUSY 5
`define ACP_ST_VALID 4
`define ACP_ST_FIXED 2
`define ACP_ST_RSVD1 1
`define ACP_ST_LOCK 0
`define ACP_FRAME_BITS 5'h10
`define ACP_CTRL_BITS 5'h08
`endif

// file: verif/acp_control_port_props.sv
// Concurrent checks on the control port outputs
`timescale 1ns/100ps
module acp_control_port_props (
  input wire clk,
  input wire arst_n,
  input wire port_mode_select,
  input wire port_sel_n,
  input wire shift_clk,
  input wire serial_io_line_out,
  input wire serial_io_line_oe,
  input wire power_state_pin,
  input wire chan_a_active,
  input wire chan_b_active,
  input wire chan_a_standby,
  input wire chan_b_standby,
  input wire full_power_down,
  input wire average_mode,
  input wire strap_format
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // Idle port, strap mode and quiet power pin, long enough to pass syncs
  sequence selIdle; port_sel_n [*5]; endsequence
  sequence strapMode; port_mode_select [*5]; endsequence
  sequence pwrQuiet; (port_sel_n && $stable(power_state_pin)) [*6];
  endsequence
  a_oe_sel_idle: assert property (selIdle |-> !serial_io_line_oe)
    else $error("data line driven with select high");
  a_oe_mode_idle: assert property (strapMode |-> !serial_io_line_oe)
    else $error("data line driven in strap mode");
  a_oe_rise_fall: assert property ($rose(serial_io_line_oe) |->
    !port_sel_n && !shift_clk) else $error("read drive not after fall");
  a_out_on_fall: assert property (serial_io_line_oe &&
    $changed(serial_io_line_out) |-> !shift_clk)
    else $error("read bit changed with shift clock high");
  a_avg_both_on: assert property (average_mode |-> chan_a_active &&
    chan_b_active && !chan_a_standby && !chan_b_standby)
    else $error("averaging without both channels");
  a_pd_all_off: assert property (full_power_down |-> !(chan_a_active ||
    chan_b_active || chan_a_standby || chan_b_standby))
    else $error("power-down with a channel on");
  a_act_sb_excl: assert property (!(chan_a_active && chan_a_standby) &&
    !(chan_b_active && chan_b_standby)) else $error("active and standby");
  a_pwr_hold: assert property (pwrQuiet |-> $stable({chan_a_active,
    chan_b_active, full_power_down, average_mode}))
    else $error("power state moved without cause");
  a_strap_hold: assert property (!port_mode_select [*4] |=>
    $stable(strap_format)) else $error("strap moved in serial mode");
endmodule
bind acp_control_port acp_control_port_props props_u (.clk(clk),
  .arst_n(arst_n), .port_mode_select(port_mode_select),
  .port_sel_n(port_sel_n), .shift_clk(shift_clk),
  .serial_io_line_out(serial_io_line_out),
  .serial_io_line_oe(serial_io_line_oe), .power_state_pin(power_state_pin),
  .chan_a_active(chan_a_active), .chan_b_active(chan_b_active),
  .chan_a_standby(chan_a_standby), .chan_b_standby(chan_b_standby),
  .full_power_down(full_power_down), .average_mode(average_mode),
  .strap_format(strap_format));

// file: verif/acp_host.sv
// Host model driving the three-wire serial control port
`timescale 1ns/100ps
module acp_host (
  input wire clk,
  input wire lineVal,
  output logic selN,
  output logic sck,
  output logic hostBit,
  output logic hostOe
);
  // Idle: select high, shift clock still and low
  initial begin
    selN = 1'b1;
    sck = 1'b0;
    hostBit = 1'b0;
    hostOe = 1'b0;
  end
  // One cycle: control byte then data byte, MSB first
  task automatic xfer(input bit rd, input bit [6:0] adr, input bit [7:0] wd,
      output bit [7:0] rdat);
    bit [15:0] frm;
    frm = {rd, adr, wd};
    @(posedge clk) selN <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      hostOe <= !(rd && i < 8);
      hostBit <= frm[i];
      repeat (8) @(posedge clk);
      rdat = {rdat[6:0], lineVal};
      sck <= 1'b1;
      repeat (8) @(posedge clk);
      sck <= 1'b0;
    end
    hostOe <= 1'b0;
    repeat (8) @(posedge clk);
    selN <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  // Strap levels on the shared pins, {data, clock, select}
  task automatic strap(input bit [2:0] v);
    selN <= v[0];
    sck <= v[1];
    hostBit <= v[2];
    hostOe <= 1'b1;
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the control port and register bank
`timescale 1ns/100ps
module testbench;
  logic clk = 1'b0, rstN = 1'b0, modeSel = 1'b0, pwrPin = 1'b0;
  logic [3:0] stat = 4'h0;
  logic selN, sck, hostBit, hostOe, devOut, devOe, lineVal;
  logic [5:0] pw;
  logic [4:1] fm;
  logic [2:0] sp;
  logic [47:0] regs;
  bit [2:0] sv;
  int mdl[0:8];
  int miscompares = 0, checked = 0, cyc = 0;
  bit [31:0] seed = 32'd43071;
  bit [7:0] rd;
  always #10 clk = ~clk;
  // Released line shows the inverse of the last host bit
  assign lineVal = devOe ? devOut : hostOe ? hostBit : ~hostBit;
  acp_control_port dut_u (.clk(clk), .arst_n(rstN),
    .port_mode_select(modeSel), .port_sel_n(selN), .shift_clk(sck),
    .serial_io_line_in(lineVal), .serial_io_line_out(devOut),
    .serial_io_line_oe(devOe), .power_state_pin(pwrPin),
    .rom_load_busy(stat[3]), .rom_load_valid(stat[2]),
    .status_rsvd1(stat[1]), .dll_locked(stat[0]), .chan_a_active(pw[5]),
    .chan_b_active(pw[4]), .chan_a_standby(pw[3]), .chan_b_standby(pw[2]),
    .full_power_down(pw[1]), .average_mode(pw[0]),
    .interleaved_output_enable(fm[1]), .interleave_bus_select(fm[2]),
    .chan_a_reverse(fm[3]), .chan_b_reverse(fm[4]), .strap_format(sp[2]),
    .strap_divider(sp[1]), .bus_mode_strap(sp[0]),
    .output_driver_power(regs[7:0]), .data_clock_timing(regs[15:8]),
    .chan_a_termination(regs[23:16]), .chan_b_termination(regs[31:24]),
    .divider_format_pattern(regs[39:32]), .input_common_mode(regs[47:40]));
  acp_host host_u (.clk(clk), .lineVal(lineVal), .selN(selN), .sck(sck),
    .hostBit(hostBit), .hostOe(hostOe));
  ////////////////////////////////////////////////////////////////////////
  function automatic bit [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected {aAct, bAct, aStby, bStby, powerDown, average}
  function automatic logic [5:0] pwrExp(int r, bit pin);
    bit [3:0] n;
    bit aOn, bOn;
    n = pin ? r[7:4] : r[3:0];
    aOn = n[0] | n[3] & n[1];
    bOn = n[1] | n[3] & n[0];
    return {aOn, bOn, !aOn & n[2], !bOn & n[2], !(n[0] | n[1] | n[2]),
      n[3] & (n[0] | n[1])};
  endfunction
  task automatic chk(input logic [7:0] got, input int exp);
    checked++;
    if (got !== exp[7:0]) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp[7:0]);
    end
  endtask
  task automatic wr(input bit [6:0] a, input int d);
    host_u.xfer(1'b0, a, d[7:0], rd);
    if (a <= 8 && a != 7) mdl[a] = d & 255;
    if (a == 10 && d[7:0] == 8'h5A) mdl = '{3, 0, 0, 109, 0, 0, 0, 0, 0};
  endtask
  task automatic rdc(input bit [6:0] a, input int exp);
    host_u.xfer(1'b1, a, 8'h00, rd);
    chk(rd, exp);
  endtask
  task automatic pwrChk();
    for (int p = 0; p < 2; p++) begin
      pwrPin <= p[0];
      repeat (4) @(posedge clk);
      chk({2'b00, pw}, pwrExp(mdl[0], p[0]));
    end
  endtask
  // Register outputs 02h-06h and 08h against the model
  task automatic regChk();
    for (int a = 2; a <= 8; a++)
      if (a != 7) chk(regs[8 * (a - 2 - a / 8) +: 8], mdl[a]);
  endtask
  task automatic wrap_up();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Cycle ceiling against a hung port
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mdl = '{3, 0, 0, 109, 0, 0, 0, 0, 0};
    repeat (8) @(posedge clk);
    rstN <= 1'b1;
    repeat (4) @(posedge clk);
    modeSel <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (3) begin
      sv = 3'(rnd());
      host_u.strap(sv);
      repeat (6) @(posedge clk);
      chk({5'h00, sp}, sv);
    end
    host_u.strap(3'h1);
    repeat (6) @(posedge clk);
    modeSel <= 1'b0;
    repeat (6) @(posedge clk);
    for (int a = 0; a <= 8; a++) if (a != 7) rdc(a, mdl[a]);
    pwrChk();
    $display("test reset values done");
    for (int a = 0; a <= 8; a++)
      if (a != 7) wr(a, a == 1 ? rnd() & 30 : rnd());
    wr(7'h0B, 255);
    wr(7'h0A, 8'hA5);
    for (int a = 0; a <= 8; a++) if (a != 7) rdc(a, mdl[a]);
    rdc(7'h0B, 0);
    regChk();
    chk({3'h0, fm, 1'b0}, mdl[1]);
    $display("test write and readback done");
    repeat (4) begin
      stat <= 4'(rnd());
      @(posedge clk);
      rdc(7'h0A, {2'b00, stat[3:2], 2'b01, stat[1:0]});
    end
    $display("test status byte done");
    repeat (8) begin
      wr(7'h00, rnd());
      pwrChk();
    end
    $display("test power decode done");
    wr(7'h0A, 8'h5A);
    pwrChk();
    rdc(7'h01, mdl[1]);
    regChk();
    chk({3'h0, fm, 1'b0}, mdl[1]);
    $display("test soft reset done");
    wrap_up();
  end
endmodule

// file: verilog/acp_control_port.v
// Serial control port, register bank and power/bus mode decode
//
// Function
// - Mode pin low selects serial port; high selects parallel strap mode.
// - Data line captured on rising shift clock while select is low.
// - With select high, clock and data activity are ignored.
// - Cycle is a control byte then one data byte.
// - First bit direction (1 read), 7 address bits, 8 data bits.
// - Address and data travel most significant bit first.
// - Read data driven after falling edge following eighth rising edge.
// - Writing 5Ah to 0Ah restores all control registers to defaults.
// - Status bit 5 ROM load busy, bit 4 load done and valid.
// - Status bit 0 DLL lock; bits 7,6,3 zero; bit 2 one.
// - Shutdown pin picks low or high nibble of power register.
// - Default power value: shutdown high powers down, low full power.
// - Enabled channels active; disabled ones standby or power down.
// - Averaging with any channel enabled runs both, output (A+B)/2.
// - With averaging, standby or power-down only if both enables clear.
// - Format bit 1: dual buses when 0, one multiplexed bus when 1.
// - Format bit 2 picks multiplexed and averaged bus, first channel.
// - Format bits 4 and 3 reverse channel B and A pin order.
// - Shared pins are straps for format, divider, bus mode when high.
`timescale 1ns/100ps
`include "acp_map.vh"
module acp_control_port (
  input wire clk,
  input wire arst_n,
  input wire port_mode_select,
  input wire port_sel_n,
  input wire shift_clk,
  input wire serial_io_line_in,
  output reg serial_io_line_out,
  output reg serial_io_line_oe,
  input wire power_state_pin,
  input wire rom_load_busy,
  input wire rom_load_valid,
  input wire dll_locked,
  input wire status_rsvd1,
  output reg chan_a_active,
  output reg chan_b_active,
  output reg chan_a_standby,
  output reg chan_b_standby,
  output reg full_power_down,
  output reg average_mode,
  output reg interleaved_output_enable,
  output reg interleave_bus_select,
  output reg chan_a_reverse,
  output reg chan_b_reverse,
  output reg strap_format,
  output reg strap_divider,
  output reg bus_mode_strap,
  output reg [7:0] output_driver_power,
  output reg [7:0] data_clock_timing,
  output reg [7:0] chan_a_termination,
  output reg [7:0] chan_b_termination,
  output reg [7:0] divider_format_pattern,
  output reg [7:0] input_common_mode
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire [4:0] pinSync;
  wire pwrSync;
  wire modeSync;
  wire selActSync;
  wire sckSync;
  wire sdiSync;

  // Select enters inverted so the reset value reads as deselected
  acp_sync #(.W(5)) uSync (
    .clk(clk),
    .arst_n(arst_n),
    .din({power_state_pin, port_mode_select, !port_sel_n, shift_clk,
      serial_io_line_in}),
    .dout(pinSync)
  );

  assign pwrSync = pinSync[4];
  assign modeSync = pinSync[3];
  assign selActSync = pinSync[2];
  assign sckSync = pinSync[1];
  assign sdiSync = pinSync[0];

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised clock
  reg sckDly_ff;
  wire serialOn;
  wire sckRise;
  wire sckFall;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sckDly_ff <= 1'b0;
    end else begin
      sckDly_ff <= sckSync;
    end
  end

  assign serialOn = !modeSync && selActSync;
  assign sckRise = serialOn && sckSync && !sckDly_ff;
  assign sckFall = serialOn && !sckSync && sckDly_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter
  reg [4:0] bitCnt_ff;
  reg [15:0] shift_ff;
  reg [7:0] readSh_ff;
  reg readFrame_ff;
  reg [7:0] readData;
  wire [15:0] nxt_shift;
  wire frameDone;

  assign nxt_shift = {shift_ff[14:0], sdiSync};
  assign frameDone = sckRise && (bitCnt_ff == `ACP_FRAME_BITS - 5'h01);

  // Bit counter and read flag cleared while deselected; shift register holds
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bitCnt_ff <= 5'h00;
      shift_ff <= 16'h0000;
      readFrame_ff <= 1'b0;
    end else if (!serialOn) begin
      bitCnt_ff <= 5'h00;
      readFrame_ff <= 1'b0;
    end else if (sckRise && bitCnt_ff < `ACP_FRAME_BITS) begin
      bitCnt_ff <= bitCnt_ff + 5'h01;
      shift_ff <= nxt_shift;
      if (bitCnt_ff == 5'h00) begin
        readFrame_ff <= sdiSync;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bank
  reg [7:0] pwrReg_ff;
  reg [7:0] fmtReg_ff;
  wire softReset;
  wire doWrite;
  wire [6:0] wrAddr;

  assign wrAddr = nxt_shift[14:8]; // Address sits below the direction bit
  assign doWrite = frameDone && !readFrame_ff;
  assign softReset = doWrite && wrAddr == `ACP_ADDR_KEY &&
    nxt_shift[7:0] == `ACP_KEY_VALUE;

  // Writes to listed registers; reserved and unlisted ignored
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwrReg_ff <= `ACP_RST_PWR;
      fmtReg_ff <= `ACP_RST_FMT;
      output_driver_power <= `ACP_RST_DRV;
      data_clock_timing <= `ACP_RST_TIM;
      chan_a_termination <= `ACP_RST_TRA;
      chan_b_termination <= `ACP_RST_TRB;
      divider_format_pattern <= `ACP_RST_DIV;
      input_common_mode <= `ACP_RST_CMI;
    end else if (softReset) begin
      pwrReg_ff <= `ACP_RST_PWR;
      fmtReg_ff <= `ACP_RST_FMT;
      output_driver_power <= `ACP_RST_DRV;
      data_clock_timing <= `ACP_RST_TIM;
      chan_a_termination <= `ACP_RST_TRA;
      chan_b_termination <= `ACP_RST_TRB;
      divider_format_pattern <= `ACP_RST_DIV;
      input_common_mode <= `ACP_RST_CMI;
    end else if (doWrite) begin
      case (wrAddr)
        `ACP_ADDR_PWR: pwrReg_ff <= nxt_shift[7:0];
        `ACP_ADDR_FMT: fmtReg_ff <= nxt_shift[7:0];
        `ACP_ADDR_DRV: output_driver_power <= nxt_shift[7:0];
        `ACP_ADDR_TIM: data_clock_timing <= nxt_shift[7:0];
        `ACP_ADDR_TRA: chan_a_termination <= nxt_shift[7:0];
        `ACP_ADDR_TRB: chan_b_termination <= nxt_shift[7:0];
        `ACP_ADDR_DIV: divider_format_pattern <= nxt_shift[7:0];
        `ACP_ADDR_CMI: input_common_mode <= nxt_shift[7:0];
        default: pwrReg_ff <= pwrReg_ff;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux and status byte
  wire [7:0] statusByte;

  assign statusByte = {2'b00, rom_load_busy, rom_load_valid, 1'b0, 1'b1,
    status_rsvd1, dll_locked};

  always @* begin
    case (shift_ff[6:0])
      `ACP_ADDR_PWR: readData = pwrReg_ff;
      `ACP_ADDR_FMT: readData = fmtReg_ff;
      `ACP_ADDR_DRV: readData = output_driver_power;
      `ACP_ADDR_TIM: readData = data_clock_timing;
      `ACP_ADDR_TRA: readData = chan_a_termination;
      `ACP_ADDR_TRB: readData = chan_b_termination;
      `ACP_ADDR_DIV: readData = divider_format_pattern;
      `ACP_ADDR_CMI: readData = input_common_mode;
      `ACP_ADDR_KEY: readData = statusByte;
      default: readData = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data driver: load on falling edge after eighth rise
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readSh_ff <= 8'h00;
      serial_io_line_out <= 1'b0;
      serial_io_line_oe <= 1'b0;
    end else if (!serialOn) begin
      serial_io_line_oe <= 1'b0;
      serial_io_line_out <= 1'b0;
    end else if (sckFall && readFrame_ff &&
                 bitCnt_ff == `ACP_CTRL_BITS) begin
      serial_io_line_out <= readData[7];
      readSh_ff <= {readData[6:0], 1'b0};
      serial_io_line_oe <= 1'b1;
    end else if (sckFall && serial_io_line_oe) begin
      if (bitCnt_ff == `ACP_FRAME_BITS) begin
        serial_io_line_oe <= 1'b0;
      end else begin
        serial_io_line_out <= readSh_ff[7];
        readSh_ff <= {readSh_ff[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state decode
  wire [3:0] pwrSel;
  wire anyOn;

  assign pwrSel = pwrSync ? pwrReg_ff[7:4] : pwrReg_ff[3:0];
  assign anyOn = pwrSel[`ACP_PWR_CHA] | pwrSel[`ACP_PWR_CHB];

  // Default 03h: state0 both on, state1 all off
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chan_a_active <= 1'b0;
      chan_b_active <= 1'b0;
      chan_a_standby <= 1'b0;
      chan_b_standby <= 1'b0;
      full_power_down <= 1'b1;
      average_mode <= 1'b0;
    end else if (pwrSel[`ACP_PWR_AVG] && anyOn) begin
      chan_a_active <= 1'b1;
      chan_b_active <= 1'b1;
      chan_a_standby <= 1'b0;
      chan_b_standby <= 1'b0;
      full_power_down <= 1'b0;
      average_mode <= 1'b1;
    end else begin
      chan_a_active <= pwrSel[`ACP_PWR_CHA];
      chan_b_active <= pwrSel[`ACP_PWR_CHB];
      chan_a_standby <= !pwrSel[`ACP_PWR_CHA] && pwrSel[`ACP_PWR_STBY];
      chan_b_standby <= !pwrSel[`ACP_PWR_CHB] && pwrSel[`ACP_PWR_STBY];
      full_power_down <= !anyOn && !pwrSel[`ACP_PWR_STBY];
      average_mode <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output bus settings and straps
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      interleaved_output_enable <= 1'b0;
      interleave_bus_select <= 1'b0;
      chan_a_reverse <= 1'b0;
      chan_b_reverse <= 1'b0;
      strap_format <= 1'b0;
      strap_divider <= 1'b0;
      bus_mode_strap <= 1'b0;
    end else begin
      interleaved_output_enable <= fmtReg_ff[`ACP_FMT_MUX];
      interleave_bus_select <= fmtReg_ff[`ACP_FMT_MUXCH];
      chan_a_reverse <= fmtReg_ff[`ACP_FMT_ORDA];
      chan_b_reverse <= fmtReg_ff[`ACP_FMT_ORDB];
      if (modeSync) begin
        strap_format <= sdiSync;
        strap_divider <= sckSync;
        bus_mode_strap <= !selActSync;
      end
    end
  end
endmodule

// file: verilog/acp_sync.v
// Two-flop synchroniser for asynchronous pins
`timescale 1ns/100ps
module acp_sync #(
  parameter W = 1
) (
  input wire clk,
  input wire arst_n,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;

  // First stage read only by the second
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;
endmodule
